// [src/gti_core.sv]
/*
  Guard interval timer: a supervisory counter on the low-frequency clock that
  either resets the system (watchdog mode) or raises periodic requests (timer
  mode), with a classic Wishbone register slave.
  Assumes the low-frequency clock arrives as a free-running pin, power mode
  entry is signalled by same-clock logic, and rst_i resets this block too.

*/
`timescale 1ns/1ps
`include "gti_defines.svh"
module gti_core #(
  parameter int ADR_W = 8
) (
  // System clock and reset.
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // Low-frequency clock pin.
  input  wire logic              lf_clk_i,
  // Power mode entry from the power manager, same clock.
  input  wire logic              pwr_entry_i,
  input  wire logic [1:0]        pwr_mode_i,
  // Wishbone slave.
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Block outputs.
  output logic                   irq_req_o,
  output logic                   sys_rst_o
);

  // ========================================================================
  // Last count value of an interval: the counter steps past it to expire.
  function automatic logic [14:0] gti_last(input logic [1:0] intv);
    logic [15:0] len;
    len = `GTI_INTV_CNT_00;
    unique case (intv)
      2'h0: len = `GTI_INTV_CNT_00;
      2'h1: len = `GTI_INTV_CNT_01;
      2'h2: len = `GTI_INTV_CNT_10;
      2'h3: len = `GTI_INTV_CNT_11;
    endcase
    return 15'(len - 16'h0001);
  endfunction

  // ========================================================================
  // Low-frequency clock enters through a synchroniser; its rising edges are ticks.
  logic lf_level;
  logic lf_rise;
  logic lf_fall;

  gti_pin_sync u_lf_sync (
    .clk_i   (clk_sys_i),
    .rst_i   (rst_i),
    .pin_i   (lf_clk_i),
    .level_o (lf_level),
    .rise_o  (lf_rise),
    .fall_o  (lf_fall)
  );

  // ========================================================================
  // Bus slave state.
  gti_pkg::gti_bus_e bus_q;
  gti_pkg::gti_bus_e bus_d;
  logic              ack_d;
  logic [31:0]       rdat_d;
  logic              req;
  logic              wr_stb;
  logic              ctrl_hit;

  // Control state.
  gti_pkg::gti_ctrl_s ctrl_q;
  gti_pkg::gti_ctrl_s ctrl_d;
  logic               key_arm;
  logic               key_done;
  logic               cnt_zero;

  // Counter state.
  logic [14:0] cnt_q;
  logic [14:0] cnt_d;
  logic        armed_q;
  logic        armed_d;
  logic        win_half_q;
  logic        win_half_d;
  logic        expired_q;
  logic        expired_d;
  logic        irq_d;
  logic        srst_d;
  logic        deep_entry;
  logic        wd_locked;

  assign req        = wb_cyc_i & wb_stb_i;
  assign ctrl_hit   = (wb_adr_i == ADR_W'(`GTI_CTRL_OFS));
  // A write takes effect at the edge where the master samples ack.
  assign wr_stb     = req & wb_we_i & wb_ack_o & wb_sel_i[0] & ctrl_hit;
  assign wd_locked  = ctrl_q.en & ~ctrl_q.timer_mode;
  assign deep_entry = pwr_entry_i &
                      ((pwr_mode_i == `GTI_PM_RETENTION) |
                       (pwr_mode_i == `GTI_PM_DEEPEST));

  // ========================================================================
  // Bus: ack one cycle after a request is taken, dropped the cycle after.
  // Unmapped offsets are acknowledged and read as zero.
  always_comb begin
    bus_d  = bus_q;
    ack_d  = 1'b0;
    rdat_d = wb_dat_o;
    unique case (bus_q)
      gti_pkg::GTI_BUS_IDLE: begin
        if (req) begin
          bus_d  = gti_pkg::GTI_BUS_ACK;
          ack_d  = 1'b1;
          rdat_d = 32'h0000_0000;
          if (ctrl_hit) begin
            // Key field reads as zero so read-modify-write keys stay clean.
            rdat_d[`GTI_EN_BIT]                   = ctrl_q.en;
            rdat_d[`GTI_MODE_BIT]                 = ctrl_q.timer_mode;
            rdat_d[`GTI_INTV_MSB:`GTI_INTV_LSB]   = ctrl_q.intv;
          end else if (wb_adr_i == ADR_W'(`GTI_STAT_OFS)) begin
            // Status shows block state; the count itself is hidden.
            rdat_d[0] = armed_q;
            rdat_d[1] = expired_q;
            rdat_d[2] = sys_rst_o;
            rdat_d[3] = lf_level;
          end
        end
      end
      gti_pkg::GTI_BUS_ACK: begin
        bus_d = gti_pkg::GTI_BUS_IDLE;
      end
    endcase
  end

  // Bus registers.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus_q    <= gti_pkg::GTI_BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      bus_q    <= bus_d;
      wb_ack_o <= ack_d;
      wb_dat_o <= rdat_d;
    end
  end

  // ========================================================================
  // Control register writes and the key events they produce.
  always_comb begin
    logic [3:0] key;
    logic       en_w;
    key      = wb_dat_i[`GTI_KEY_MSB:`GTI_KEY_LSB];
    en_w     = wb_dat_i[`GTI_EN_BIT];
    ctrl_d   = ctrl_q;
    key_arm  = 1'b0;
    key_done = 1'b0;
    cnt_zero = 1'b0;
    if (wr_stb) begin
      ctrl_d.intv = wb_dat_i[`GTI_INTV_MSB:`GTI_INTV_LSB];
      if (!wd_locked) begin
        ctrl_d.timer_mode = wb_dat_i[`GTI_MODE_BIT];
      end
      if (en_w) begin
        ctrl_d.en = 1'b1;
        if (!ctrl_q.en) begin
          cnt_zero = 1'b1;
        end
      end else if (!wd_locked) begin
        ctrl_d.en = 1'b0;
      end
      // Keys only count while the timer already runs.
      if (ctrl_q.en) begin
        if (ctrl_q.timer_mode) begin
          cnt_zero = cnt_zero | key[0];
        end else if (key == `GTI_KEY_FIRST) begin
          key_arm = 1'b1;
        end else if (key == `GTI_KEY_SECOND && armed_q) begin
          key_done = 1'b1;
        end
      end
    end
  end

  // Control registers; the system reset leaves the timer off.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_q.en         <= `GTI_EN_RST;
      ctrl_q.timer_mode <= `GTI_MODE_RST;
      ctrl_q.intv       <= `GTI_INTV_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ========================================================================
  // Counter, key window, expiry and the two outputs.
  // The window after the first key closes at the second low-frequency edge
  // of either polarity, or at once on a deep sleep entry; without such an entry
  // it lasts at least half a period on that clock and a second key sent in time is never refused.
  always_comb begin
    logic [14:0] last;
    last      = gti_last(ctrl_q.intv);
    cnt_d     = cnt_q;
    armed_d   = armed_q;
    win_half_d = win_half_q;
    expired_d = expired_q;
    irq_d     = 1'b0;
    srst_d    = sys_rst_o;
    if (armed_q && (lf_rise || lf_fall)) begin
      if (win_half_q) begin
        armed_d    = 1'b0;
        win_half_d = 1'b0;
      end else begin
        win_half_d = 1'b1;
      end
    end
    if (ctrl_q.en && lf_rise) begin
      if (cnt_q == last) begin
        if (ctrl_q.timer_mode) begin
          cnt_d = 15'h0000;
          irq_d = 1'b1;
        end else begin
          cnt_d     = cnt_q + 15'h0001;
          expired_d = 1'b1;
        end
      end else begin
        cnt_d = cnt_q + 15'h0001;
      end
    end
    if (key_arm) begin
      armed_d    = 1'b1;
      win_half_d = 1'b0;
    end
    // A completed clear restarts the interval and forgets a pending expiry.
    if (key_done) begin
      cnt_d     = 15'h0000;
      armed_d   = 1'b0;
      win_half_d = 1'b0;
      expired_d = 1'b0;
    end
    if (cnt_zero) begin
      cnt_d     = 15'h0000;
      expired_d = 1'b0;
    end
    if (deep_entry) begin
      cnt_d     = 15'h0000;
      armed_d   = 1'b0;
      win_half_d = 1'b0;
      expired_d = 1'b0;
    end
    // Expiry while a clear is in its window waits for the second key.
    if (expired_q && !armed_q && wd_locked) begin
      srst_d = 1'b1;
    end
  end

  // Counter registers; the reset output holds until rst_i arrives.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q     <= 15'h0000;
      armed_q   <= 1'b0;
      win_half_q <= 1'b0;
      expired_q <= 1'b0;
      irq_req_o <= 1'b0;
      sys_rst_o <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      armed_q   <= armed_d;
      win_half_q <= win_half_d;
      expired_q <= expired_d;
      irq_req_o <= irq_d;
      sys_rst_o <= srst_d;
    end
  end

endmodule

// [src/gti_defines.svh]
/*
  Offsets, field positions, reset values and counts of the guard interval timer.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef GTI_DEFINES_SVH
`define GTI_DEFINES_SVH

// ==========================================================================
// Register byte offsets.
`define GTI_CTRL_OFS      8'h00
`define GTI_STAT_OFS      8'h04

// ==========================================================================
// Control register field positions.
`define GTI_KEY_MSB       7
`define GTI_KEY_LSB       4
`define GTI_EN_BIT        3
`define GTI_MODE_BIT      2
`define GTI_INTV_MSB      1
`define GTI_INTV_LSB      0

// ==========================================================================
// Reset values and key codes.
`define GTI_EN_RST        1'h0
`define GTI_MODE_RST      1'h0
`define GTI_INTV_RST      2'h0
`define GTI_KEY_FIRST     4'hA
`define GTI_KEY_SECOND    4'h5

// ==========================================================================
// Interval lengths in low-frequency clock periods, and deep sleep codes.
`define GTI_LF_FREQ_HZ    32768
`define GTI_INTV_CNT_00   16'h8000
`define GTI_INTV_CNT_01   16'h2000
`define GTI_INTV_CNT_10   16'h0200
`define GTI_INTV_CNT_11   16'h0040
`define GTI_PM_RETENTION  2'h2
`define GTI_PM_DEEPEST    2'h3

`endif

// [src/gti_pin_sync.sv]
/*
  Three-stage synchroniser for an asynchronous pin with edge pulses.
  Assumes clk_i is the only clock; the pin may change at any time.
*/
`timescale 1ns/1ps
module gti_pin_sync (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin and synchronised results.
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       lvl_d;
  logic       rise_d;
  logic       fall_d;

  // ========================================================================
  // A change counts only once stages two and three agree.
  always_comb begin
    sh_d   = {sh_q[1:0], pin_i};
    lvl_d  = level_o;
    if (sh_q[2] == sh_q[1]) begin
      lvl_d = sh_q[2];
    end
    rise_d = lvl_d & ~level_o;
    fall_d = ~lvl_d & level_o;
  end

  // Registers only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_q    <= 3'h0;
      level_o <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      sh_q    <= sh_d;
      level_o <= lvl_d;
      rise_o  <= rise_d;
      fall_o  <= fall_d;
    end
  end

endmodule

// [src/gti_pkg.sv]
/*
  Types shared by the guard interval timer.
  Assumes the constants header is included by users that need numbers.
*/
package gti_pkg;

  // ========================================================================
  // Control fields as held by the block.
  typedef struct packed {
    logic       en;
    logic       timer_mode;
    logic [1:0] intv;
  } gti_ctrl_s;

  // ========================================================================
  // Bus slave states.
  typedef enum logic [0:0] {
    GTI_BUS_IDLE = 1'b0,
    GTI_BUS_ACK  = 1'b1
  } gti_bus_e;

endpackage

// [tb/gti_core_monitor.sv]
/*
  Port checker for gti_core, bound into every instance of it.
  Assumes the lf pin period is well above eight system clocks.
*/
`timescale 1ns/1ps
module gti_core_monitor (
  // Clock, reset and inputs.
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        pwr_entry_i,
  input wire logic [1:0]  pwr_mode_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  // Outputs under watch.
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq_req_o,
  input wire logic        sys_rst_o
);
  // ==========================================================================
  // Checks. All of them live in the system clock domain.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_deep;
    pwr_entry_i && pwr_mode_i[1];
  endsequence
  a_ack_one_pulse: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not one pulse one cycle after the request");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data has bits above the low byte");
  a_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_req_o && !sys_rst_o)
    else $error("outputs active right after reset");
  a_sysrst_sticky: assert property (sys_rst_o |=> sys_rst_o)
    else $error("system reset dropped without rst_i");
  a_irq_spacing: assert property (irq_req_o |=> !irq_req_o [*8])
    else $error("interval request repeated too soon");
  a_deep_quiet: assert property (s_deep |-> ##2 !irq_req_o [*8])
    else $error("request soon after deep sleep entry");
  a_wdog_no_irq: assert property (sys_rst_o |-> !irq_req_o)
    else $error("request while system reset is high");
  a_timer_no_rst: assert property (irq_req_o |=> !$rose(sys_rst_o))
    else $error("system reset follows a timer request");
endmodule

bind gti_core gti_core_monitor gti_core_monitor_i (
  .clk_sys_i, .rst_i, .pwr_entry_i, .pwr_mode_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .irq_req_o, .sys_rst_o
);

// [tb/gti_core_tb.sv]
/*
  Self-checking bench for gti_core using Wishbone tasks and timed waits.
  Assumes a one-cycle ack and drives the lf pin itself.
*/
`timescale 1ns/1ps
module gti_core_tb;
  // ==========================================================================
  // Signals. Half lf period is wide enough for two key writes in one window.
  localparam int LFH = 16;
  localparam int LFP = 2 * LFH;
  logic        clk_sys_i, rst_i, lf_clk_i, pwr_entry_i;
  logic [1:0]  pwr_mode_i;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_req_o, sys_rst_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          errors, cmp_count, irqs, cyc, c0, n, k;

  gti_core #(.ADR_W(8)) gti_core_i (
    .clk_sys_i, .rst_i, .lf_clk_i, .pwr_entry_i, .pwr_mode_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_req_o,
    .sys_rst_o
  );

  // ==========================================================================
  // Clocks. The lf pin runs free, changed just after system edges.
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    lf_clk_i = 1'b0;
    forever begin
      repeat (LFH) @(posedge clk_sys_i);
      lf_clk_i <= ~lf_clk_i;
    end
  end
  // Cycle and request counters; non-blocking so readers see a stable value.
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (rst_i) begin
      irqs <= 0;
    end else if (irq_req_o === 1'b1) begin
      irqs <= irqs + 1;
    end
  end

  // ==========================================================================
  // Tasks.
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // One classic cycle: hold everything until ack is sampled, then release.
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk_sys_i);
    if (i == 20) begin
      errors++;
      finish_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'h1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, 4'h1);
    chk(rd, e);
  endtask
  // Waits for a request (s=0) or system reset (s=1); c returns lim if none.
  task automatic wait_out(input bit s, input int lim, input bit must, output int c);
    c = 0;
    do begin
      @(posedge clk_sys_i);
      c++;
    end while ((s ? sys_rst_o : irq_req_o) !== 1'b1 && c < lim);
    if (must && c >= lim) begin
      errors++;
      finish_test();
    end
  endtask
  // Key pair placed mid half-period so a synced lf edge cannot split it.
  task automatic kclear(input int gap);
    int i;
    int j;
    for (i = 0; i < LFP && lf_clk_i !== 1'b0; i++) @(posedge clk_sys_i);
    for (j = 0; j < LFP && lf_clk_i !== 1'b1; j++) @(posedge clk_sys_i);
    // A stuck lf pin is a failure, not a reason to send keys blindly.
    if (i == LFP || j == LFP) begin
      errors++;
      finish_test();
    end
    repeat (8) @(posedge clk_sys_i);
    wr(8'h00, 32'h0000_00AB);
    repeat (gap) @(posedge clk_sys_i);
    wr(8'h00, 32'h0000_005B);
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    {rst_i, pwr_entry_i, pwr_mode_i, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    {wb_adr_i, wb_dat_i, errors, cmp_count} = '0;
    wb_sel_i = 4'h1;
    do_reset();
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h10, 32'h0000_0000);
    for (k = 0; k < 4; k++) begin
      wr(8'h00, 32'(k));
      rdc(8'h00, 32'(k));
    end
    // A write without byte lane zero must leave the control byte alone.
    xfer(1'b1, 8'h00, 32'h0000_000F, 4'h0);
    rdc(8'h00, 32'h0000_0003);
    wait_out(1'b1, 3000, 1'b0, n);
    chk_rng(n, 3000, 3000);
    $display("test reset done");
    wr(8'h00, 32'h0000_000F);
    wait_out(1'b0, 3000, 1'b1, n);
    chk_rng(n, 63 * LFP - 4, 64 * LFP + 8);
    wait_out(1'b0, 3000, 1'b1, n);
    chk(32'(n), 32'(64 * LFP));
    for (k = 0; k < 3; k++) begin
      wait_out(1'b0, 3000, 1'b1, n);
      repeat (1000) @(posedge clk_sys_i);
      if (k == 0) begin
        wr(8'h00, 32'h0000_001F);
      end else begin
        pwr_entry_i <= 1'b1;
        pwr_mode_i  <= 2'(k + 1);
        @(posedge clk_sys_i);
        pwr_entry_i <= 1'b0;
      end
      wait_out(1'b0, 3000, 1'b1, n);
      chk_rng(n, 63 * LFP - 4, 64 * LFP + 8);
    end
    wr(8'h00, 32'h0000_0007);
    wait_out(1'b0, 3000, 1'b0, n);
    chk_rng(n, 3000, 3000);
    wr(8'h00, 32'h0000_000E);
    wait_out(1'b0, 20000, 1'b1, n);
    chk_rng(n, 511 * LFP - 4, 512 * LFP + 8);
    chk({31'h0, sys_rst_o}, 32'h0000_0000);
    $display("test timer done");
    do_reset();
    wr(8'h00, 32'h0000_000B);
    wr(8'h00, 32'h0000_0003);
    wr(8'h00, 32'h0000_000F);
    rdc(8'h00, 32'h0000_000B);
    wr(8'h00, 32'h0000_000A);
    rdc(8'h00, 32'h0000_000A);
    wr(8'h00, 32'h0000_000B);
    kclear(0);
    for (k = 0; k < 3; k++) begin
      wait_out(1'b1, 1500, 1'b0, n);
      chk_rng(n, 1500, 1500);
      kclear(0);
    end
    // First key just before the expiring tick, second key just after it:
    // the expiry must wait in the window and the clear must still win.
    repeat (2028) @(posedge clk_sys_i);
    wr(8'h00, 32'h0000_00AB);
    repeat (8) @(posedge clk_sys_i);
    rdc(8'h04, 32'h0000_000B);
    wr(8'h00, 32'h0000_005B);
    wait_out(1'b1, 1500, 1'b0, n);
    chk_rng(n, 1500, 1500);
    kclear(0);
    c0 = cyc;
    repeat (1000) @(posedge clk_sys_i);
    kclear(40);
    wait_out(1'b1, 3000, 1'b1, n);
    chk_rng(cyc - c0, 63 * LFP - 4, 64 * LFP + 8);
    chk(32'(irqs), 32'h0000_0000);
    $display("test watchdog done");
    finish_test();
  end
endmodule
